/* File: rtl/svic_pkg.sv */
// Purpose: constants for the six source vectored interrupt unit
// Assumes: 8-bit data memory bus of the core, 13-bit program counter
// Notes: register offsets are data memory locations
package svic_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] SVIC_CTRL_LOW_ADDR = 8'h0B;
  localparam logic [7:0] SVIC_CTRL_HIGH_ADDR = 8'h1E;
  localparam logic [7:0] SVIC_CTRL_LOW_RST = 8'h00;
  localparam logic [7:0] SVIC_CTRL_HIGH_RST = 8'h00;
  // ==========================================================
  // low control register fields
  localparam int SVIC_GIE_BIT = 0;
  localparam int SVIC_EXT0_EN_BIT = 1;
  localparam int SVIC_EXT1_EN_BIT = 2;
  localparam int SVIC_TMR0_EN_BIT = 3;
  localparam int SVIC_EXT0_FLAG_BIT = 4;
  localparam int SVIC_EXT1_FLAG_BIT = 5;
  localparam int SVIC_TMR0_FLAG_BIT = 6;
  // ==========================================================
  // high control register fields
  localparam int SVIC_TMR1_EN_BIT = 0;
  localparam int SVIC_TICK_EN_BIT = 1;
  localparam int SVIC_RTC_EN_BIT = 2;
  localparam int SVIC_TMR1_FLAG_BIT = 4;
  localparam int SVIC_TICK_FLAG_BIT = 5;
  localparam int SVIC_RTC_FLAG_BIT = 6;
  // ==========================================================
  // sources, index equals priority order (0 highest)
  localparam int SVIC_NSRC = 6;
  localparam int SVIC_PC_W = 13;
  localparam int SVIC_STACK_DEPTH = 16;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_EXT0 = 13'h0004;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_EXT1 = 13'h0008;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_TMR0 = 13'h000C;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_TMR1 = 13'h0010;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_TICK = 13'h0014;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_RTC = 13'h0018;
  localparam logic [SVIC_PC_W-1:0] SVIC_VEC_NONE = 13'h0000;
  // ==========================================================
  // phase divider: four phases per instruction cycle
  localparam int SVIC_PHASES = 4;
  localparam logic [1:0] SVIC_PHASE_TWO = 2'h1;
endpackage : svic_pkg

/* File: rtl/svic_edge_sync.sv */
// Purpose: two-stage synchroniser with falling edge detect
// Assumes: input is asynchronous to sys_clk
// Notes: fall pulse lasts one cycle
`timescale 1ns/10ps
`default_nettype none
module svic_edge_sync
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // line
  input wire logic line_in,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } svic_sync_t;
  svic_sync_t st_r;
  svic_sync_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = line_in;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  // idle high so that reset release is not seen as an edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= 3'b111;
    else
      st_r <= st_nxt;
  end

  assign fall = st_r.last & ~st_r.sync;
endmodule : svic_edge_sync
`default_nettype wire

/* File: rtl/svic_top.sv */
// Purpose: six source vectored interrupt unit of an 8-bit core
// Assumes: core presents data memory writes and reads, return
//          stack state and instruction events on sys_clk
// Notes: acknowledge is taken only on the phase-two enable
//
// Overview of operation
// - six sources, each flag plus enable
// - acknowledge clears global enable
// - blocked requests still set their flags
// - stack full blocks every acknowledge
// - any source flag wakes halted core
// - push only PC, then branch vector
// - external falling edges set bits four, five
// - external vectors 04H, 08H; clear flag
// - timer 0 flag bit six, vector 0CH
// - timer 1 flag high bit four, 10H
// - tick flag high bit five, vector 14H
// - rtc flag high bit six, vector 18H
// - service holds others until re-enabled
// - reenabling return sets global enable
// - requests served on next phase-two edge
// - fixed priority ext0 first, rtc last
// - global enable clear masks all sources
// - low register at 0BH layout
// - high register at 1EH layout
// - low bits zero-three enables, seven zero
// - high bits zero-two enables, three/seven zero
// - flags hold until serviced or cleared
// - sixteen level stack, full blocks
`timescale 1ns/10ps
`default_nettype none
module svic_top
#(
  parameter int STACK_DEPTH = svic_pkg::SVIC_STACK_DEPTH
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // external lines, active low edges
  input wire logic ext_line_0,
  input wire logic ext_line_1,
  // internal events, one-cycle pulses on sys_clk
  input wire logic tmr0_overflow,
  input wire logic tmr1_overflow,
  input wire logic tick_event,
  input wire logic rtc_event,
  // data memory access from the core
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  output logic mem_hit,
  // program sequencer
  input wire logic [svic_pkg::SVIC_PC_W-1:0] pc_value,
  input wire logic [4:0] stack_index,
  input wire logic reenabling_return,
  input wire logic plain_return,
  input wire logic halted,
  // acknowledge to the sequencer
  output logic irq_ack,
  output logic [svic_pkg::SVIC_PC_W-1:0] irq_vector,
  output logic [svic_pkg::SVIC_PC_W-1:0] push_pc,
  output logic wake_up,
  output logic phase_two_clock
);
  import svic_pkg::*;

  // the 5-bit stack index cannot count past 31 levels
  if (STACK_DEPTH < 1 || STACK_DEPTH > 31)
  begin : g_bad_depth
    $error("svic_top: STACK_DEPTH out of range");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] phase;
    logic gie;
    logic [SVIC_NSRC-1:0] en;
    logic [SVIC_NSRC-1:0] flag;
    logic ack;
    logic [SVIC_PC_W-1:0] vector;
    logic [SVIC_PC_W-1:0] pc;
    logic [7:0] rdata;
    logic hit;
    logic wake;
  } svic_state_t;
  svic_state_t st_r;
  svic_state_t st_nxt;

  // ==========================================================
  // vector per source index
  function automatic logic [SVIC_PC_W-1:0] svic_vec(input logic [2:0] idx);
    case (idx)
      3'h0: svic_vec = SVIC_VEC_EXT0;
      3'h1: svic_vec = SVIC_VEC_EXT1;
      3'h2: svic_vec = SVIC_VEC_TMR0;
      3'h3: svic_vec = SVIC_VEC_TMR1;
      3'h4: svic_vec = SVIC_VEC_TICK;
      3'h5: svic_vec = SVIC_VEC_RTC;
      default: svic_vec = SVIC_VEC_NONE;
    endcase
  endfunction : svic_vec

  // low register image from state
  function automatic logic [7:0] svic_low(input svic_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[SVIC_GIE_BIT] = s.gie;
    v[SVIC_EXT0_EN_BIT] = s.en[0];
    v[SVIC_EXT1_EN_BIT] = s.en[1];
    v[SVIC_TMR0_EN_BIT] = s.en[2];
    v[SVIC_EXT0_FLAG_BIT] = s.flag[0];
    v[SVIC_EXT1_FLAG_BIT] = s.flag[1];
    v[SVIC_TMR0_FLAG_BIT] = s.flag[2];
    svic_low = v;
  endfunction : svic_low

  function automatic logic [7:0] svic_high(input svic_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[SVIC_TMR1_EN_BIT] = s.en[3];
    v[SVIC_TICK_EN_BIT] = s.en[4];
    v[SVIC_RTC_EN_BIT] = s.en[5];
    v[SVIC_TMR1_FLAG_BIT] = s.flag[3];
    v[SVIC_TICK_FLAG_BIT] = s.flag[4];
    v[SVIC_RTC_FLAG_BIT] = s.flag[5];
    svic_high = v;
  endfunction : svic_high

  // one address decode shared by the write and read sides
  function automatic logic [1:0] svic_sel(input logic [7:0] addr);
    svic_sel = 2'b00;
    if (addr == SVIC_CTRL_LOW_ADDR)
      svic_sel = 2'b01;
    if (addr == SVIC_CTRL_HIGH_ADDR)
      svic_sel = 2'b10;
  endfunction : svic_sel

  // ==========================================================
  // external edge detection
  logic ext0_fall;
  logic ext1_fall;

  svic_edge_sync u_sync0
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .line_in(ext_line_0),
    .fall(ext0_fall)
  );

  svic_edge_sync u_sync1
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .line_in(ext_line_1),
    .fall(ext1_fall)
  );

  // ==========================================================
  // next state
  logic [SVIC_NSRC-1:0] hw_set;
  logic [SVIC_NSRC-1:0] pending;
  logic [SVIC_NSRC-1:0] grant;
  logic stack_full;
  logic phase_en;
  logic ack_allowed;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;
  logic [1:0] reg_sel;
  logic [2:0] win_idx;

  assign hw_set = {rtc_event, tick_event, tmr1_overflow, tmr0_overflow,
                   ext1_fall, ext0_fall};
  assign stack_full = (stack_index >= 5'(STACK_DEPTH));
  assign phase_en = (st_r.phase == SVIC_PHASE_TWO);
  // stack room and the phase-two point both gate the acknowledge
  assign ack_allowed = phase_en && !stack_full;
  assign reg_sel = svic_sel(mem_addr);
  assign wr_low = mem_wr && reg_sel[0];
  assign wr_high = mem_wr && reg_sel[1];
  assign rd_low = mem_rd && reg_sel[0];
  assign rd_high = mem_rd && reg_sel[1];
  // global enable gates every source
  assign pending = st_r.flag & st_r.en & {SVIC_NSRC{st_r.gie}};

  // lowest index wins
  always_comb
  begin
    grant = '0;
    win_idx = 3'h7;
    for (int i = SVIC_NSRC - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        win_idx = 3'(i);
      end
    end
    if (win_idx != 3'h7 && ack_allowed)
      grant[win_idx] = 1'b1;
  end

  // ==========================================================
  // request flags
  wire logic [SVIC_NSRC-1:0] sw_flag;
  wire logic [SVIC_NSRC-1:0] flag_nxt;

  // software image first; a write of one raises a flag as well
  assign sw_flag[0] = wr_low ? mem_wdata[SVIC_EXT0_FLAG_BIT] : st_r.flag[0];
  assign sw_flag[1] = wr_low ? mem_wdata[SVIC_EXT1_FLAG_BIT] : st_r.flag[1];
  assign sw_flag[2] = wr_low ? mem_wdata[SVIC_TMR0_FLAG_BIT] : st_r.flag[2];
  assign sw_flag[3] = wr_high ? mem_wdata[SVIC_TMR1_FLAG_BIT] : st_r.flag[3];
  assign sw_flag[4] = wr_high ? mem_wdata[SVIC_TICK_FLAG_BIT] : st_r.flag[4];
  assign sw_flag[5] = wr_high ? mem_wdata[SVIC_RTC_FLAG_BIT] : st_r.flag[5];
  for (genvar g = 0; g < SVIC_NSRC; g++)
  begin : g_flag
    // hardware set last, so it beats a same-cycle clear
    assign flag_nxt[g] = (sw_flag[g] & ~grant[g]) | hw_set[g];
  end

  always_comb
  begin
    st_nxt = st_r;
    // wrap on the phase count, not on the counter width
    if (st_r.phase == 2'(SVIC_PHASES - 1))
      st_nxt.phase = 2'h0;
    else
      st_nxt.phase = st_r.phase + 2'h1;
    st_nxt.ack = 1'b0;
    // software writes first; hardware events and acks override
    if (wr_low)
    begin
      st_nxt.gie = mem_wdata[SVIC_GIE_BIT];
      st_nxt.en[0] = mem_wdata[SVIC_EXT0_EN_BIT];
      st_nxt.en[1] = mem_wdata[SVIC_EXT1_EN_BIT];
      st_nxt.en[2] = mem_wdata[SVIC_TMR0_EN_BIT];
    end
    if (wr_high)
    begin
      st_nxt.en[3] = mem_wdata[SVIC_TMR1_EN_BIT];
      st_nxt.en[4] = mem_wdata[SVIC_TICK_EN_BIT];
      st_nxt.en[5] = mem_wdata[SVIC_RTC_EN_BIT];
    end
    if (reenabling_return)
      st_nxt.gie = 1'b1;
    if (|grant)
    begin
      st_nxt.gie = 1'b0;
      st_nxt.ack = 1'b1;
      st_nxt.vector = svic_vec(win_idx);
      st_nxt.pc = pc_value;
    end
    // flags stick; winner cleared; a new event wins the same cycle
    st_nxt.flag = flag_nxt;
    st_nxt.wake = halted && (|st_r.flag);
    st_nxt.hit = rd_low || rd_high;
    if (rd_low)
      st_nxt.rdata = svic_low(st_r);
    else if (rd_high)
      st_nxt.rdata = svic_high(st_r);
    else
      st_nxt.rdata = 8'h00;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r.phase <= 2'h0;
      st_r.gie <= SVIC_CTRL_LOW_RST[SVIC_GIE_BIT];
      st_r.en <= '0;
      st_r.flag <= '0;
      st_r.ack <= 1'b0;
      st_r.vector <= SVIC_VEC_NONE;
      st_r.pc <= '0;
      st_r.rdata <= 8'h00;
      st_r.hit <= 1'b0;
      st_r.wake <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign irq_ack = st_r.ack;
  assign irq_vector = st_r.vector;
  assign push_pc = st_r.pc;
  assign mem_rdata = st_r.rdata;
  assign mem_hit = st_r.hit;
  assign wake_up = st_r.wake;
  assign phase_two_clock = phase_en;

  // plain return leaves the global enable alone
  logic unused_ok;
  assign unused_ok = plain_return;
endmodule : svic_top
`default_nettype wire

/* File: sim/svic_seq_model.sv */
// Purpose: program sequencer stack model
// Assumes: one push per acknowledge
// Notes: fill forces a full stack
`timescale 1ns/10ps
`default_nettype none
module svic_seq_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // sequencer events
  input wire logic irq_ack,
  input wire logic reenabling_return,
  input wire logic plain_return,
  input wire logic fill,
  // stack state
  output logic [4:0] stack_index,
  output logic [12:0] pc_value
);
  // ==========================================
  // stack
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stack_index <= 5'h00;
      pc_value <= 13'h0100;
    end
    else
    begin
      // moving pc exposes a stale push
      pc_value <= pc_value + 13'h0001;
      if (fill)
        stack_index <= 5'h10;
      else if (irq_ack)
        stack_index <= stack_index + 5'h01;
      else if ((reenabling_return || plain_return) && stack_index != 5'h00)
        stack_index <= stack_index - 5'h01;
    end
  end
endmodule : svic_seq_model
`default_nettype wire

/* File: sim/svic_top_props.sv */
// Purpose: port checks for the interrupt unit
// Assumes: only top ports are visible
// Notes: bound to every svic_top
`timescale 1ns/10ps
`default_nettype none
module svic_top_props
#(
  parameter int STACK_DEPTH = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // watched ports
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_hit,
  input wire logic [12:0] pc_value,
  input wire logic [4:0] stack_index,
  input wire logic halted,
  input wire logic irq_ack,
  input wire logic [12:0] irq_vector,
  input wire logic [12:0] push_pc,
  input wire logic wake_up,
  input wire logic phase_two_clock
);
  // ==========================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_gap; irq_ack |=> !irq_ack [*3]; endproperty
  a_gap: assert property (p_gap) else $error("ack repeated");
  property p_t2; irq_ack |-> $past(phase_two_clock); endproperty
  a_t2: assert property (p_t2) else $error("ack off phase");
  property p_room; irq_ack |-> $past(stack_index) < STACK_DEPTH; endproperty
  a_room: assert property (p_room) else $error("ack on full");
  property p_push; irq_ack |-> push_pc == $past(pc_value); endproperty
  a_push: assert property (p_push) else $error("bad push");
  property p_vec;
    irq_ack |-> irq_vector inside {13'h04, 13'h08, 13'h0C, 13'h10, 13'h14, 13'h18};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_ph; phase_two_clock |=> !phase_two_clock [*3] ##1 phase_two_clock; endproperty
  a_ph: assert property (p_ph) else $error("phase spacing");
  property p_wake; wake_up |-> $past(halted); endproperty
  a_wake: assert property (p_wake) else $error("wake unhalted");
  property p_hit; mem_hit |-> $past(mem_rd) && $past(mem_addr) inside {8'h0B, 8'h1E}; endproperty
  a_hit: assert property (p_hit) else $error("stray hit");
  property p_b7; mem_hit |-> !mem_rdata[7]; endproperty
  a_b7: assert property (p_b7) else $error("bit 7 set");
endmodule : svic_top_props
bind svic_top svic_top_props #(.STACK_DEPTH(STACK_DEPTH)) chk_u (.sys_clk, .rst_b,
  .mem_addr, .mem_rd, .mem_rdata, .mem_hit, .pc_value, .stack_index, .halted,
  .irq_ack, .irq_vector, .push_pc, .wake_up, .phase_two_clock);
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: self-checking bench for the interrupt unit
// Assumes: sequencer model owns the stack index
// Notes: ev bits 0-1 hold external lines low
`timescale 1ns/10ps
`default_nettype none
module tb;
  import svic_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0] mem_addr = 8'h00;
  logic [7:0] mem_wdata = 8'h00;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic reenabling_return = 1'b0;
  logic plain_return = 1'b0;
  logic halted = 1'b0;
  logic fill = 1'b0;
  logic [7:0] mem_rdata;
  logic mem_hit, irq_ack, wake_up;
  logic [12:0] irq_vector, pc_value;
  logic [4:0] stack_index;
  int err_total = 0;
  int checks = 0;
  always #4 sys_clk = ~sys_clk;
  svic_top #(.STACK_DEPTH(16)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .ext_line_0(~ev[0]), .ext_line_1(~ev[1]), .tmr0_overflow(ev[2]),
    .tmr1_overflow(ev[3]), .tick_event(ev[4]), .rtc_event(ev[5]),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_hit(mem_hit), .pc_value(pc_value),
    .stack_index(stack_index), .reenabling_return(reenabling_return), .plain_return(plain_return),
    .halted(halted), .irq_ack(irq_ack), .irq_vector(irq_vector), .push_pc(),
    .wake_up(wake_up), .phase_two_clock());
  svic_seq_model seq_u (.sys_clk(sys_clk), .rst_b(rst_b), .irq_ack(irq_ack),
    .reenabling_return(reenabling_return), .plain_return(plain_return), .fill(fill),
    .stack_index(stack_index), .pc_value(pc_value));
  // ==========================================
  // helpers
  task automatic print_verdict();
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge sys_clk);
    mem_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge sys_clk);
    mem_rd <= 1'b0;
    #1;
    chk(13'(mem_rdata), 13'(e));
  endtask : rdc
  task automatic fire(input logic [5:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= m & 6'h03;
    repeat (3) @(posedge sys_clk);
    ev <= 6'h00;
    repeat (2) @(posedge sys_clk);
  endtask : fire
  task automatic rt(input logic re);
    @(posedge sys_clk);
    reenabling_return <= re;
    plain_return <= !re;
    @(posedge sys_clk);
    reenabling_return <= 1'b0;
    plain_return <= 1'b0;
  endtask : rt
  task automatic ack(input logic [12:0] e);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (irq_ack === 1'b1)
      begin
        chk(irq_vector, e);
        return;
      end
    end
    err_total++;
    print_verdict();
  endtask : ack
  task automatic quiet();
    repeat (12)
    begin
      @(posedge sys_clk);
      #1;
      chk(13'(irq_ack), 13'h0000);
    end
  endtask : quiet
  // ==========================================
  // scenarios
  task automatic t_regs();
    rdc(SVIC_CTRL_LOW_ADDR, SVIC_CTRL_LOW_RST);
    chk(13'(mem_hit), 13'h0001);
    rdc(SVIC_CTRL_HIGH_ADDR, SVIC_CTRL_HIGH_RST);
    rdc(8'h0C, 8'h00);
    chk(13'(mem_hit), 13'h0000);
    wr(8'h0B, 8'h8F);
    wr(8'h1E, 8'h8F);
    rdc(8'h0B, 8'h0F);
    rdc(8'h1E, 8'h07);
  endtask : t_regs
  task automatic t_prio();
    wr(8'h0B, 8'h0E);
    fire(6'h3F);
    quiet();
    rdc(8'h0B, 8'h7E);
    rdc(8'h1E, 8'h77);
    wr(8'h0B, 8'h7F);
    ack(SVIC_VEC_EXT0);
    rdc(8'h0B, 8'h6E);
    for (int k = 1; k < 6; k++)
    begin
      rt(1'b1);
      ack(13'(4 * k + 4));
    end
    rt(1'b0);
    rdc(8'h0B, 8'h0E);
    rdc(8'h1E, 8'h07);
  endtask : t_prio
  task automatic t_full();
    @(posedge sys_clk);
    fill <= 1'b1;
    wr(8'h0B, 8'h09);
    fire(6'h04);
    quiet();
    rdc(8'h0B, 8'h49);
    @(posedge sys_clk);
    halted <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(13'(wake_up), 13'h0001);
    @(posedge sys_clk);
    halted <= 1'b0;
    fill <= 1'b0;
    rt(1'b1);
    ack(SVIC_VEC_TMR0);
    fire(6'h04);
    quiet();
    rdc(8'h0B, 8'h48);
  endtask : t_full
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_prio();
    t_full();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
